// [adsc_sequencer.sv]
`timescale 1ns/100ps
// converter sequencing control: registers, delays, start/abort, window
module adsc_sequencer (
   input  wire logic        mclk_i,           // peripheral clock, 100 MHz
   input  wire logic        rst_b_i,          // async reset, active low
   input  wire logic [4:0]  addr_i,           // register byte address
   input  wire logic [7:0]  wdata_i,          // write data
   input  wire logic        wr_i,             // write strobe
   input  wire logic        rd_i,             // read strobe
   output logic      [7:0]  rdata_o,          // read data, next cycle
   input  wire logic        event_i,          // start event pulse
   input  wire logic        wake_i,           // deep sleep wake pulse
   input  wire logic        conv_done_i,      // converter finished
   input  wire logic [9:0]  conv_data_i,      // converter sample
   output logic [1:0]       reference_o,      // reference choice
   output logic [4:0]       input_route_o,    // applied input route
   output logic             adc_clk_o,        // converter clock
   output logic             adc_tick_o,       // converter cycle pulse
   output logic             sample_open_o,    // sampling cap open
   output logic             conv_start_o,     // start conversion pulse
   output logic             irq_result_o,     // result ready request
   output logic             irq_window_o      // window match request
);
   // software visible state
   logic        run_enable;
   logic        free_run;
   logic [1:0]  reference_choice;
   logic [2:0]  clock_divider_sel;
   logic [2:0]  startup_delay_sel;
   logic        auto_delay_vary;
   logic [3:0]  sample_spacing;
   logic [2:0]  window_compare_mode;
   logic [4:0]  sample_length_ext;
   logic [4:0]  input_route;
   logic        event_start_enable;
   logic [1:0]  irq_enable;
   logic        result_ready;
   logic        window_match;
   logic [15:0] conversion_result;
   logic [15:0] window_low_threshold;
   logic [15:0] window_high_threshold;
   // sequencing state
   adsc_pkg::adsc_state_t state;
   logic        init_pending;
   logic [8:0]  count;
   logic [8:0]  next_count;
   logic        tick;
   logic        win_hit;
   logic [15:0] next_result;
   // decoded accesses
   logic        wr_run;
   logic        wr_ref;
   logic        wr_dly;
   logic        wr_cmd;
   logic        wr_flags;
   logic        rd_result;
   logic        start_req;
   logic        abort_req;
   logic        sample_done;
   logic        busy;

   adsc_pkg::adsc_state_t next_state;

   assign wr_run   = wr_i && (addr_i == adsc_pkg::ADDR_RUN_CONTROL);
   assign wr_ref   = wr_i && (addr_i == adsc_pkg::ADDR_REF_PRESCALE);
   assign wr_dly   = wr_i && (addr_i == adsc_pkg::ADDR_DELAY_CONTROL);
   assign wr_cmd   = wr_i && (addr_i == adsc_pkg::ADDR_COMMAND);
   assign wr_flags = wr_i && (addr_i == adsc_pkg::ADDR_INT_FLAGS);
   assign rd_result = rd_i && ((addr_i == adsc_pkg::ADDR_RESULT_LO) ||
                               (addr_i == adsc_pkg::ADDR_RESULT_HI));
   assign busy = (state != adsc_pkg::ST_IDLE);

   // a start only counts while enabled and idle; software or event
   assign start_req = run_enable && !busy &&
      ((wr_cmd && wdata_i[adsc_pkg::BIT_START]) ||
       (event_start_enable && event_i));
   assign abort_req = busy && ((wr_cmd && !wdata_i[adsc_pkg::BIT_START]) ||
                               !run_enable);
   assign sample_done = (state == adsc_pkg::ST_CONV) && conv_done_i;
   // one sample per measurement; the sum is the sample widened to 16 bits
   assign next_result = {6'h00, conv_data_i};

   adsc_clock_divider u_div (
      .mclk_i    (mclk_i),
      .rst_b_i   (rst_b_i),
      .run_i     (run_enable),
      .div_sel_i (clock_divider_sel),
      .tick_o    (tick),
      .clk_o     (adc_clk_o)
   );

   // compare the fresh result, not the stored one, so the flag is timely
   adsc_window_compare u_win (
      .mode_i  (window_compare_mode),
      .value_i (next_result),
      .low_i   (window_low_threshold),
      .high_i  (window_high_threshold),
      .match_o (win_hit)
   );

   // run control (own layout) and reference / prescaler fields
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         run_enable        <= 1'b0;
         free_run          <= 1'b0;
         reference_choice  <= adsc_pkg::REF_INTERNAL;
         clock_divider_sel <= 3'h0;
      end else begin
         if (wr_run) begin
            run_enable <= wdata_i[adsc_pkg::BIT_ENABLE];
            free_run   <= wdata_i[adsc_pkg::BIT_FREERUN];
         end
         if (wr_ref) begin
            reference_choice  <= wdata_i[adsc_pkg::POS_REF +: 2];
            clock_divider_sel <= wdata_i[adsc_pkg::POS_CLOCK_DIVIDER_SEL +: 3];
         end
      end
   end

   // delay control; software write beats the automatic step
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         startup_delay_sel <= 3'h0;
         auto_delay_vary   <= 1'b0;
         sample_spacing    <= 4'h0;
      end else if (wr_dly) begin
         startup_delay_sel <= wdata_i[adsc_pkg::POS_STARTDLY +: 3];
         auto_delay_vary   <= wdata_i[adsc_pkg::BIT_AUTO_DELAY_VARY];
         sample_spacing    <= wdata_i[adsc_pkg::POS_SPACING +: 4];
      end else if (auto_delay_vary && sample_done) begin
         sample_spacing <= sample_spacing + 4'h1;
      end
   end

   // remaining plain configuration registers
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         window_compare_mode   <= adsc_pkg::WIN_NONE;
         sample_length_ext     <= 5'h00;
         input_route           <= 5'h00;
         event_start_enable    <= 1'b0;
         irq_enable            <= 2'h0;
         window_low_threshold  <= 16'h0000;
         window_high_threshold <= 16'h0000;
      end else if (wr_i) begin
         case (addr_i)
            adsc_pkg::ADDR_WINDOW_MODE:   window_compare_mode <= wdata_i[2:0];
            adsc_pkg::ADDR_SAMPLE_LENGTH: sample_length_ext <= wdata_i[4:0];
            adsc_pkg::ADDR_INPUT_SELECT:  input_route <= wdata_i[4:0];
            adsc_pkg::ADDR_EVENT_CONTROL: event_start_enable <= wdata_i[0];
            adsc_pkg::ADDR_INT_ENABLE:    irq_enable <= wdata_i[1:0];
            adsc_pkg::ADDR_WIN_LOW_LO:  window_low_threshold[7:0] <= wdata_i;
            adsc_pkg::ADDR_WIN_LOW_HI:  window_low_threshold[15:8] <= wdata_i;
            adsc_pkg::ADDR_WIN_HIGH_LO: window_high_threshold[7:0] <= wdata_i;
            adsc_pkg::ADDR_WIN_HIGH_HI: window_high_threshold[15:8] <= wdata_i;
            default: ;
         endcase
      end
   end

   // startup delay is owed after enable, a switch to the internal
   // reference, or a wake; a new cause in the consuming cycle wins
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         init_pending <= 1'b0;
      end else if ((wr_run && wdata_i[adsc_pkg::BIT_ENABLE] && !run_enable)
                || (wr_ref && (wdata_i[adsc_pkg::POS_REF +: 2] ==
                               adsc_pkg::REF_INTERNAL) &&
                    (reference_choice != adsc_pkg::REF_INTERNAL))
                || wake_i) begin
         init_pending <= 1'b1;
      end else if (state == adsc_pkg::ST_INIT) begin
         init_pending <= 1'b0;
      end
   end

   // sequencing: init delay, spacing, sampling, conversion
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         adsc_pkg::ST_IDLE: begin
            if (start_req && init_pending) begin
               next_state = adsc_pkg::ST_INIT;
               next_count = adsc_pkg::startup_ticks(startup_delay_sel);
            end else if (start_req) begin
               next_state = adsc_pkg::ST_SAMPLE;
               next_count = adsc_pkg::SAMPLE_BASE_TICKS +
                            9'(sample_length_ext);
            end
         end
         adsc_pkg::ST_INIT: begin
            if (count == 9'h000) begin
               next_state = adsc_pkg::ST_SAMPLE;
               next_count = adsc_pkg::SAMPLE_BASE_TICKS +
                            9'(sample_length_ext);
            end else if (tick) begin
               next_count = count - 9'h001;
            end
         end
         adsc_pkg::ST_SPACE: begin
            if (count == 9'h000) begin
               next_state = adsc_pkg::ST_SAMPLE;
               next_count = adsc_pkg::SAMPLE_BASE_TICKS +
                            9'(sample_length_ext);
            end else if (tick) begin
               next_count = count - 9'h001;
            end
         end
         adsc_pkg::ST_SAMPLE: begin
            if (count == 9'h000) begin
               next_state = adsc_pkg::ST_CONV;
            end else if (tick) begin
               next_count = count - 9'h001;
            end
         end
         adsc_pkg::ST_CONV: begin
            if (conv_done_i && free_run) begin
               next_state = adsc_pkg::ST_SPACE;
               next_count = 9'(sample_spacing);
            end else if (conv_done_i) begin
               next_state = adsc_pkg::ST_IDLE;
            end
         end
         default: begin
            next_state = adsc_pkg::ST_IDLE;
            next_count = 9'h000;
         end
      endcase
      if (abort_req) begin
         next_state = adsc_pkg::ST_IDLE;
         next_count = 9'h000;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= adsc_pkg::ST_IDLE;
         count <= 9'h000;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // result capture and sticky flags; a set beats a clear in one cycle
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         conversion_result <= 16'h0000;
         result_ready      <= 1'b0;
         window_match      <= 1'b0;
      end else begin
         if (sample_done) begin
            conversion_result <= next_result;
         end
         if (sample_done) begin
            result_ready <= 1'b1;
         end else if (rd_result ||
                      (wr_flags && wdata_i[adsc_pkg::BIT_RESULT_READY])) begin
            result_ready <= 1'b0;
         end
         if (sample_done && win_hit) begin
            window_match <= 1'b1;
         end else if (rd_result ||
                      (wr_flags && wdata_i[adsc_pkg::BIT_WINDOW])) begin
            window_match <= 1'b0;
         end
      end
   end

   // applied route only follows the register between conversions
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         input_route_o <= 5'h00;
      end else if (!busy || sample_done) begin
         input_route_o <= input_route;
      end
   end

   // converter side outputs, all from flops
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reference_o   <= adsc_pkg::REF_INTERNAL;
         adc_tick_o    <= 1'b0;
         sample_open_o <= 1'b0;
         conv_start_o  <= 1'b0;
         irq_result_o  <= 1'b0;
         irq_window_o  <= 1'b0;
      end else begin
         reference_o   <= reference_choice;
         adc_tick_o    <= tick;
         // cap stays open across spacing and sampling
         sample_open_o <= (next_state == adsc_pkg::ST_SPACE) ||
                          (next_state == adsc_pkg::ST_SAMPLE);
         conv_start_o  <= (state == adsc_pkg::ST_SAMPLE) &&
                          (next_state == adsc_pkg::ST_CONV);
         irq_result_o  <= irq_enable[adsc_pkg::BIT_RESULT_READY] &&
                          result_ready;
         irq_window_o  <= irq_enable[adsc_pkg::BIT_WINDOW] &&
                          window_match;
      end
   end

   // read mux, answered one cycle after the strobe; holes read zero
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o <= adsc_pkg::BYTE_ZERO;
      end else if (!rd_i) begin
         rdata_o <= adsc_pkg::BYTE_ZERO;
      end else begin
         case (addr_i)
            adsc_pkg::ADDR_RUN_CONTROL:   rdata_o <= {6'h00, free_run,
                                                      run_enable};
            adsc_pkg::ADDR_REF_PRESCALE:  rdata_o <= {2'h0, reference_choice,
                                                      1'b0, clock_divider_sel};
            adsc_pkg::ADDR_DELAY_CONTROL: rdata_o <= {startup_delay_sel,
                                            auto_delay_vary, sample_spacing};
            adsc_pkg::ADDR_WINDOW_MODE:   rdata_o <= {5'h00,
                                                      window_compare_mode};
            adsc_pkg::ADDR_SAMPLE_LENGTH: rdata_o <= {3'h0, sample_length_ext};
            adsc_pkg::ADDR_INPUT_SELECT:  rdata_o <= {3'h0, input_route};
            adsc_pkg::ADDR_COMMAND:       rdata_o <= {7'h00, busy};
            adsc_pkg::ADDR_EVENT_CONTROL: rdata_o <= {7'h00,
                                                      event_start_enable};
            adsc_pkg::ADDR_INT_ENABLE:    rdata_o <= {6'h00, irq_enable};
            adsc_pkg::ADDR_INT_FLAGS:     rdata_o <= {6'h00, window_match,
                                                      result_ready};
            adsc_pkg::ADDR_RESULT_LO:   rdata_o <= conversion_result[7:0];
            adsc_pkg::ADDR_RESULT_HI:   rdata_o <= conversion_result[15:8];
            adsc_pkg::ADDR_WIN_LOW_LO:  rdata_o <= window_low_threshold[7:0];
            adsc_pkg::ADDR_WIN_LOW_HI:  rdata_o <= window_low_threshold[15:8];
            adsc_pkg::ADDR_WIN_HIGH_LO: rdata_o <= window_high_threshold[7:0];
            adsc_pkg::ADDR_WIN_HIGH_HI: rdata_o <= window_high_threshold[15:8];
            default:                    rdata_o <= adsc_pkg::BYTE_ZERO;
         endcase
      end
   end
endmodule

// [adsc_pkg.sv]
// Operation
// - reference field: 0 internal reference, 1 supply rail, others reserved
// - converter clock is peripheral clock divided by 2 shl code
// - startup delay of 0,16,32,64,128,256 converter cycles before first sample
// - startup delay also applied on wake from deep sleep
// - auto delay variation adds one to sample spacing after each sample
// - auto-varied spacing wraps from fifteen to zero
// - wait spacing converter cycles between samples, capacitor kept open
// - window modes: none, below low, above high, strictly inside, outside
// - window compares full 16-bit result with 16-bit thresholds
// - sampling lasts two converter cycles plus the extension field
// - input route code selects pins 0-11, dac, reference, sensor, ground
// - input route change during conversion waits until that conversion ends
// - writing one to start bit begins measurement, first one in free run
// - start bit reads one while busy, clears itself when done
// - writing zero to start bit while busy aborts the conversion
// - with event start enabled an incoming event starts a conversion
// - window interrupt request is window enable and window flag
// - result interrupt request is result enable and result flag
// - window compared at end of each conversion, sets window flag
// - result flag set on completion, cleared by write one or result read
// - thresholds apply to the accumulated sum, not single samples; here the sum is one sample widened to 16 bits
package adsc_pkg;
   // register byte offsets
   localparam logic [4:0] ADDR_RUN_CONTROL     = 5'h00;
   localparam logic [4:0] ADDR_REF_PRESCALE    = 5'h02;
   localparam logic [4:0] ADDR_DELAY_CONTROL   = 5'h03;
   localparam logic [4:0] ADDR_WINDOW_MODE     = 5'h04;
   localparam logic [4:0] ADDR_SAMPLE_LENGTH   = 5'h05;
   localparam logic [4:0] ADDR_INPUT_SELECT    = 5'h06;
   localparam logic [4:0] ADDR_COMMAND         = 5'h08;
   localparam logic [4:0] ADDR_EVENT_CONTROL   = 5'h09;
   localparam logic [4:0] ADDR_INT_ENABLE      = 5'h0A;
   localparam logic [4:0] ADDR_INT_FLAGS       = 5'h0B;
   localparam logic [4:0] ADDR_RESULT_LO       = 5'h10;
   localparam logic [4:0] ADDR_RESULT_HI       = 5'h11;
   localparam logic [4:0] ADDR_WIN_LOW_LO      = 5'h12;
   localparam logic [4:0] ADDR_WIN_LOW_HI      = 5'h13;
   localparam logic [4:0] ADDR_WIN_HIGH_LO     = 5'h14;
   localparam logic [4:0] ADDR_WIN_HIGH_HI     = 5'h15;
   // field positions
   localparam int BIT_ENABLE   = 0;
   localparam int BIT_FREERUN  = 1;
   localparam int POS_REF      = 4;
   localparam int POS_CLOCK_DIVIDER_SEL    = 0;
   localparam int POS_STARTDLY = 5;
   localparam int BIT_AUTO_DELAY_VARY     = 4;
   localparam int POS_SPACING  = 0;
   localparam int BIT_START    = 0;
   localparam int BIT_RESULT_READY   = 0;
   localparam int BIT_WINDOW   = 1;
   // codes and counts
   localparam logic [1:0] REF_INTERNAL      = 2'h0;
   localparam logic [1:0] REF_SUPPLY        = 2'h1;
   localparam logic [8:0] SAMPLE_BASE_TICKS = 9'h002;
   localparam logic [7:0] BYTE_ZERO         = 8'h00;
   localparam logic [2:0] WIN_NONE          = 3'h0;
   localparam logic [2:0] WIN_BELOW         = 3'h1;
   localparam logic [2:0] WIN_ABOVE         = 3'h2;
   localparam logic [2:0] WIN_INSIDE        = 3'h3;
   localparam logic [2:0] WIN_OUTSIDE       = 3'h4;
   localparam logic [2:0] CLOCK_DIVIDER_SEL_SHIFT_BASE  = 3'h1;
   typedef enum logic [4:0] {
      ST_IDLE   = 5'b00001,
      ST_INIT   = 5'b00010,
      ST_SPACE  = 5'b00100,
      ST_SAMPLE = 5'b01000,
      ST_CONV   = 5'b10000
   } adsc_state_t;
   // startup delay code to converter cycles; reserved codes give zero
   function automatic logic [8:0] startup_ticks(input logic [2:0] code);
      case (code)
         3'h1:    startup_ticks = 9'h010;
         3'h2:    startup_ticks = 9'h020;
         3'h3:    startup_ticks = 9'h040;
         3'h4:    startup_ticks = 9'h080;
         3'h5:    startup_ticks = 9'h100;
         default: startup_ticks = 9'h000;
      endcase
   endfunction
endpackage

// [adsc_clock_divider.sv]
`timescale 1ns/100ps
// converter clock made as a tick and a level from the peripheral clock
module adsc_clock_divider (
   input  wire logic       mclk_i,     // peripheral clock
   input  wire logic       rst_b_i,    // async reset, active low
   input  wire logic       run_i,      // divider runs while high
   input  wire logic [2:0] div_sel_i,  // divide by 2 shl code
   output logic            tick_o,     // one pulse per converter cycle
   output logic            clk_o       // converter clock level
);
   logic [7:0] count;
   logic [7:0] mask;

   // period is 2^(code+1); mask marks the last count of a period
   assign mask = 8'((9'h002 << div_sel_i) - 9'h001);

   // counter held at zero while run_i is low so the first tick has a fixed phase
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         count  <= 8'h00;
         tick_o <= 1'b0;
         clk_o  <= 1'b0;
      end else if (!run_i) begin
         count  <= 8'h00;
         tick_o <= 1'b0;
         clk_o  <= 1'b0;
      end else begin
         count  <= ((count & mask) == mask) ? 8'h00 : count + 8'h01;
         tick_o <= ((count & mask) == mask);
         clk_o  <= ((count & mask) <= (mask >> 1)); // even duty
      end
   end
endmodule

// [adsc_window_compare.sv]
`timescale 1ns/100ps
// window comparator on the full result word
module adsc_window_compare (
   input  wire logic [2:0]  mode_i,    // window compare mode
   input  wire logic [15:0] value_i,   // accumulated result
   input  wire logic [15:0] low_i,     // low threshold
   input  wire logic [15:0] high_i,    // high threshold
   output logic             match_o    // value meets the mode
);
   // unsigned compares over all sixteen bits
   always_comb begin
      case (mode_i)
         adsc_pkg::WIN_BELOW:   match_o = value_i < low_i;
         adsc_pkg::WIN_ABOVE:   match_o = value_i > high_i;
         adsc_pkg::WIN_INSIDE:  match_o = (value_i > low_i) &&
                                          (value_i < high_i);
         adsc_pkg::WIN_OUTSIDE: match_o = (value_i < low_i) ||
                                          (value_i > high_i);
         default:               match_o = 1'b0;
      endcase
   end
endmodule

// [adsc_sequencer_monitor.sv]
`timescale 1ns/100ps
// watches bus answers, start pulses and request levels
module adsc_sequencer_monitor (
   input wire logic       mclk_i, rst_b_i, wr_i, rd_i, conv_done_i, // bus
   input wire logic [4:0] addr_i, input_route_o,                    // addr
   input wire logic [7:0] wdata_i, rdata_o,                         // data
   input wire logic [1:0] reference_o,                              // ref
   input wire logic       sample_open_o, conv_start_o,              // seq
   input wire logic       irq_result_o, irq_window_o                // irq
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // a completion at the read edge would set the flags again, so exclude it
   sequence res_read_s;
      rd_i && addr_i == adsc_pkg::ADDR_RESULT_LO && !conv_done_i;
   endsequence
   sequence en_wr_s;
      wr_i && addr_i == adsc_pkg::ADDR_INT_ENABLE;
   endsequence
   rd_idle_a: assert property (!$past(rd_i) |-> !rdata_o)
      else $error("read data not idle");
   rsv_zero_a: assert property (rd_i
      && addr_i == adsc_pkg::ADDR_INT_ENABLE |=> !rdata_o[7:2])
      else $error("reserved bits not zero");
   ref_write_a: assert property (wr_i && wdata_i[5:4] == 2'h1
      && addr_i == adsc_pkg::ADDR_REF_PRESCALE |=> ##1 reference_o == 2'h1)
      else $error("reference not taken");
   ref_hold_a: assert property ($changed(reference_o)
      |-> $past(wr_i, 2)) else $error("reference moved alone");
   start_pulse_a: assert property (conv_start_o
      |=> !conv_start_o) else $error("start pulse too long");
   route_frozen_a: assert property (sample_open_o
      && $past(sample_open_o) |-> $stable(input_route_o))
      else $error("route moved");
   res_mask_a: assert property (en_wr_s ##0 !wdata_i[0]
      |=> ##1 !irq_result_o) else $error("result request unmasked");
   win_mask_a: assert property (en_wr_s ##0 !wdata_i[1]
      |=> ##1 !irq_window_o) else $error("window request unmasked");
   res_clear_a: assert property (res_read_s |=> ##1 !irq_result_o
      && !irq_window_o) else $error("flags kept after read");
endmodule
bind adsc_sequencer adsc_sequencer_monitor i_adsc_sequencer_monitor (
   .mclk_i(mclk_i), .rst_b_i(rst_b_i), .wr_i(wr_i), .rd_i(rd_i),
   .conv_done_i(conv_done_i), .addr_i(addr_i), .input_route_o(input_route_o),
   .wdata_i(wdata_i), .rdata_o(rdata_o), .reference_o(reference_o),
   .sample_open_o(sample_open_o), .conv_start_o(conv_start_o),
   .irq_result_o(irq_result_o), .irq_window_o(irq_window_o));

// [adsc_sequencer_tb_top.sv]
`timescale 1ns/100ps
// self-checking bench for the sequencing control
module adsc_sequencer_tb_top;
   logic       mclk_i = 0, rst_b_i = 0, wr_i = 0, rd_i = 0, event_i = 0;
   logic       conv_done_i = 0, adc_clk_o, adc_tick_o, sample_open_o;
   logic       conv_start_o, irq_result_o, irq_window_o, wake_i = 0;
   logic [4:0] addr_i = 5'h00, input_route_o;
   logic [7:0] wdata_i = 8'h00, rdata_o;
   logic [9:0] conv_data_i = 10'h000;
   logic [1:0] reference_o;
   int         mismatches = 0, comparisons = 0, cycles = 0;
   adsc_sequencer i_adsc_sequencer (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .event_i(event_i), .wake_i(wake_i),
      .conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
      .reference_o(reference_o), .input_route_o(input_route_o),
      .adc_clk_o(adc_clk_o), .adc_tick_o(adc_tick_o),
      .sample_open_o(sample_open_o), .conv_start_o(conv_start_o),
      .irq_result_o(irq_result_o), .irq_window_o(irq_window_o));
   always #5 mclk_i = ~mclk_i;
   // a hang counts as a mismatch
   always @(posedge mclk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (mismatches == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cmp(input logic [7:0] g, e);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // bus cycles; the extra edge keeps a strobe from being set twice at once
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(posedge mclk_i);
      cmp(rdata_o, e);
   endtask
   // wait for the start pulse, then answer as the converter
   task automatic conv(input logic [9:0] d);
      for (int n = 0; n < 300 && conv_start_o !== 1'b1; n++)
         @(posedge mclk_i);
      cmp({7'h00, conv_start_o}, 8'h01);
      conv_data_i <= d;
      conv_done_i <= 1'b1;
      @(posedge mclk_i);
      conv_done_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
   endtask
   task automatic regs_check();
      logic [4:0] a [8] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0A,
                            5'h07};
      logic [7:0] m [8] = '{8'hFF, 8'h07, 8'h1F, 8'h1F, 8'h00, 8'h01, 8'h03,
                            8'h00};
      for (int i = 0; i < 8; i++) begin
         rd(a[i], 8'h00);
         wr(a[i], 8'hFF);
         rd(a[i], m[i]);
         wr(a[i], 8'h00);
      end
      wr(adsc_pkg::ADDR_REF_PRESCALE, 8'h10);
      @(posedge mclk_i);
      cmp({6'h00, reference_o}, 8'h01);
      wr(adsc_pkg::ADDR_REF_PRESCALE, 8'h00);
      @(posedge mclk_i);
      cmp({6'h00, reference_o}, 8'h00);
   endtask
   // long sampling keeps the run busy while the route is rewritten
   task automatic single_check();
      wr(adsc_pkg::ADDR_RUN_CONTROL, 8'h01);
      wr(adsc_pkg::ADDR_SAMPLE_LENGTH, 8'h1F);
      wr(adsc_pkg::ADDR_INPUT_SELECT, 8'h1E);
      wr(adsc_pkg::ADDR_INT_ENABLE, 8'h01);
      wr(adsc_pkg::ADDR_COMMAND, 8'h01);
      rd(adsc_pkg::ADDR_COMMAND, 8'h01);
      wr(adsc_pkg::ADDR_INPUT_SELECT, 8'h05);
      cmp({3'h0, input_route_o}, 8'h1E);
      repeat (55) @(posedge mclk_i);
      cmp({7'h00, sample_open_o}, 8'h01);
      conv(10'h3FF);
      rd(adsc_pkg::ADDR_COMMAND, 8'h00);
      cmp({3'h0, input_route_o}, 8'h05);
      cmp({7'h00, irq_result_o}, 8'h01);
      rd(adsc_pkg::ADDR_RESULT_HI, 8'h03);
      rd(adsc_pkg::ADDR_RESULT_LO, 8'hFF);
      cmp({7'h00, irq_result_o}, 8'h00);
      wr(adsc_pkg::ADDR_COMMAND, 8'h01);
      wr(adsc_pkg::ADDR_COMMAND, 8'h00);
      rd(adsc_pkg::ADDR_COMMAND, 8'h00);
      repeat (80) @(posedge mclk_i);
      cmp({6'h00, sample_open_o, irq_result_o}, 8'h00);
   endtask
   task automatic event_check();
      wr(adsc_pkg::ADDR_EVENT_CONTROL, 8'h01);
      event_i <= 1'b1;
      @(posedge mclk_i);
      event_i <= 1'b0;
      conv(10'h001);
      wr(adsc_pkg::ADDR_INT_FLAGS, 8'h00);
      @(posedge mclk_i);
      cmp({7'h00, irq_result_o}, 8'h01);
      wr(adsc_pkg::ADDR_INT_FLAGS, 8'h01);
      @(posedge mclk_i);
      cmp({7'h00, irq_result_o}, 8'h00);
   endtask
   // below, inside and above a window of 0x0100 to 0x0200, every mode
   task automatic window_check();
      logic [9:0] v [3] = '{10'h050, 10'h180, 10'h250};
      logic [4:0] k [3] = '{5'h12, 5'h08, 5'h14};
      wr(adsc_pkg::ADDR_SAMPLE_LENGTH, 8'h00);
      wr(adsc_pkg::ADDR_WIN_LOW_HI, 8'h01);
      wr(adsc_pkg::ADDR_WIN_HIGH_HI, 8'h02);
      wr(adsc_pkg::ADDR_INT_ENABLE, 8'h02);
      for (int i = 0; i < 3; i++)
         for (int m = 0; m < 5; m++) begin
            wr(adsc_pkg::ADDR_INT_FLAGS, 8'h03);
            wr(adsc_pkg::ADDR_WINDOW_MODE, 8'(m));
            wr(adsc_pkg::ADDR_COMMAND, 8'h01);
            conv(v[i]);
            cmp({7'h00, irq_window_o}, {7'h00, k[i][m]});
         end
   endtask
   // a wake owes the startup delay; free run steps and wraps the spacing
   task automatic run_check();
      wr(adsc_pkg::ADDR_DELAY_CONTROL, 8'h3F);
      wake_i <= 1'b1;
      @(posedge mclk_i);
      wake_i <= 1'b0;
      wr(adsc_pkg::ADDR_RUN_CONTROL, 8'h03);
      wr(adsc_pkg::ADDR_COMMAND, 8'h01);
      cmp({7'h00, sample_open_o}, 8'h00);
      conv(10'h000);
      cmp({7'h00, sample_open_o}, 8'h01);
      conv(10'h000);
      rd(adsc_pkg::ADDR_DELAY_CONTROL, 8'h31);
   endtask
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      @(posedge mclk_i);
      regs_check();
      single_check();
      event_check();
      window_check();
      run_check();
      stop_test();
   end
endmodule
